//--- rtl/etc_map.svh
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH

// register byte offsets
`define ETC_OFS_CFG 8'h00
`define ETC_OFS_DIV 8'h04
`define ETC_OFS_STAT 8'h08
`define ETC_OFS_CNT 8'h0c

// configuration word field positions
`define ETC_CFG_ACT_A 0
`define ETC_CFG_ACT_B 4
`define ETC_CFG_ACT_C 8
`define ETC_CFG_SEL1 12
`define ETC_CFG_SEL2 14
`define ETC_CFG_EXT 16
`define ETC_CFG_SLOPE 17
`define ETC_CFG_RTS 18
`define ETC_ACT_STRIDE 4

// control input action codes
`define ETC_ACT_START 3'h0
`define ETC_ACT_STOP 3'h1
`define ETC_ACT_LEVEL 3'h2
`define ETC_ACT_ABORT 3'h3
`define ETC_ACT_SAVE 3'h4
`define ETC_ACT_MARK 3'h5

// status output condition codes
`define ETC_SEL_JUDGE 2'h0
`define ETC_SEL_ERROR 2'h1
`define ETC_SEL_BUSY 2'h2
`define ETC_SEL_WAIT 2'h3

// samples per division limits and reset value
`define ETC_DIV_MIN 10'h00a
`define ETC_DIV_MAX 10'h3e8
`define ETC_DIV_RST 10'h064

// status word bit positions above the synchronised pins
`define ETC_STAT_MEAS 8
`define ETC_STAT_POST 9
`define ETC_STAT_EXT 10
`define ETC_STAT_FIRST 11
`define ETC_STAT_BUSY 12

// pin idle level in the synchronisers
`define ETC_PIN_IDLE 1'h1

`endif

//--- rtl/etc_pkg.sv
package etc_pkg;
	typedef logic [2:0] etc_action_t;
	typedef logic [1:0] etc_sel_t;
	typedef enum logic [1:0] {
		st_idle,
		st_meas,
		st_post
	} etc_meas_e;
endpackage

//--- rtl/etc_sync.sv
`include "etc_map.svh"

module etc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	genvar i;
	// two stages per bit; the first stage is read by the second only
	for (i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_reg;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_reg <= `ETC_PIN_IDLE;
				q[i] <= `ETC_PIN_IDLE;
			end else begin
				meta_reg <= d[i];
				q[i] <= meta_reg;
			end
		end
	end
endmodule

//--- rtl/etc_top.sv
// Overview of operation
// - each control input selects start, stop, level, abort, save or mark
// - stop ends measurement and requests post processing
// - level input starts measuring while low, stops on going high
// - abort ends at once, no post processing, last sample may drop
// - save uses preset manual save conditions, never a prompt
// - control inputs ignored during help, manual save, self check, calib
// - status outputs rest high, pulled low only while condition holds
// - first status output: judge pass, error, busy or waiting trigger
// - second status output: judge fail, error, busy or waiting trigger
// - error condition pulls the output low while device is in error
// - busy condition pulls low whenever external start is refused
// - waiting trigger pulls low while armed and awaiting trigger
// - external sampling takes one sample per chosen edge after the first, falling default
// - external sampling never active while real-time saving enabled
// - samples per division range 10 to 1000, reset value 100
// - calculation monitor disabled while external sampling active
// - control inputs reset to start, stop and level actions
//
// Implementation choices: the address map and the AHB-Lite slave port.
`include "etc_map.svh"

module etc_top #(
	parameter int N_IN = 3,
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ctrl_input_a,
	input wire logic ctrl_input_b,
	input wire logic ctrl_input_c,
	input wire logic ext_sample_clock_in,
	input wire logic judge_pass,
	input wire logic judge_fail,
	input wire logic dev_error,
	input wire logic dev_busy,
	input wire logic wait_trig,
	input wire logic ui_inhibit,
	input wire logic post_done,
	output logic pass_status_out,
	output logic pass_status_oe,
	output logic fail_status_out,
	output logic fail_status_oe,
	output logic meas_active,
	output logic post_active,
	output logic meas_start,
	output logic meas_stop,
	output logic meas_abort,
	output logic save_req,
	output logic event_mark,
	output logic sample_strobe,
	output logic div_tick,
	output logic calc_monitor_en
);
	etc_pkg::etc_meas_e state_reg;
	etc_pkg::etc_action_t act_reg [N_IN];
	etc_pkg::etc_sel_t sel1_reg;
	etc_pkg::etc_sel_t sel2_reg;
	logic ext_reg;
	logic slope_reg;
	logic rts_reg;
	logic [9:0] div_reg;
	logic [9:0] div_cnt_reg;
	logic [CNT_W-1:0] smpl_cnt_reg;
	logic first_seen_reg;
	logic [N_IN:0] pin_raw;
	logic [N_IN:0] pin_s;
	logic [N_IN:0] prev_reg;
	logic [N_IN:0] fall;
	logic [N_IN:0] rise;
	logic [N_IN-1:0] req_start;
	logic [N_IN-1:0] req_stop;
	logic [N_IN-1:0] req_abort;
	logic [N_IN-1:0] req_save;
	logic [N_IN-1:0] req_mark;
	logic start_any;
	logic stop_any;
	logic abort_any;
	logic start_go;
	logic ext_active;
	logic smpl_edge;
	logic busy_now;
	logic cond1;
	logic cond2;
	logic ap_take;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [9:0] div_wr;
	logic [31:0] rd_mux;

	// all four terminal pins pass the synchroniser before any decode
	assign pin_raw = {ext_sample_clock_in, ctrl_input_c, ctrl_input_b,
		ctrl_input_a};
	etc_sync #(
		.WIDTH(N_IN + 1)
	) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d(pin_raw),
		.q(pin_s)
	);

	// previous synchronised level for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_reg <= '1;
		end else begin
			prev_reg <= pin_s;
		end
	end

	assign fall = prev_reg & ~pin_s;
	assign rise = ~prev_reg & pin_s;

	// per input action decode; codes 6 and 7 do nothing
	genvar i;
	for (i = 0; i < N_IN; i++) begin : g_in
		assign req_start[i] = (act_reg[i] == `ETC_ACT_START && fall[i]) ||
			(act_reg[i] == `ETC_ACT_LEVEL && !pin_s[i]);
		assign req_stop[i] = (act_reg[i] == `ETC_ACT_STOP && fall[i]) ||
			(act_reg[i] == `ETC_ACT_LEVEL && rise[i]);
		assign req_abort[i] = act_reg[i] == `ETC_ACT_ABORT && fall[i];
		assign req_save[i] = act_reg[i] == `ETC_ACT_SAVE && fall[i];
		assign req_mark[i] = act_reg[i] == `ETC_ACT_MARK && fall[i];
	end

	// requests are dropped, not deferred, while the panel blocks them
	assign start_any = !ui_inhibit && |req_start;
	assign stop_any = !ui_inhibit && |req_stop;
	assign abort_any = !ui_inhibit && |req_abort;
	assign busy_now = dev_busy || state_reg == etc_pkg::st_post;
	assign start_go = start_any && !busy_now;

	// measurement sequencing; abort outranks stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= etc_pkg::st_idle;
		end else begin
			case (state_reg)
				etc_pkg::st_idle: begin
					if (start_go) begin
						state_reg <= etc_pkg::st_meas;
					end
				end
				etc_pkg::st_meas: begin
					if (abort_any) begin
						state_reg <= etc_pkg::st_idle;
					end else if (stop_any) begin
						state_reg <= etc_pkg::st_post;
					end
				end
				etc_pkg::st_post: begin
					if (post_done) begin
						state_reg <= etc_pkg::st_idle;
					end
				end
				default: begin
					state_reg <= etc_pkg::st_idle;
				end
			endcase
		end
	end

	// one cycle command pulses and the meas_active and post_active levels towards the acquisition engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_start <= 1'b0;
			meas_stop <= 1'b0;
			meas_abort <= 1'b0;
			save_req <= 1'b0;
			event_mark <= 1'b0;
			meas_active <= 1'b0;
			post_active <= 1'b0;
		end else begin
			meas_start <= state_reg == etc_pkg::st_idle && start_go;
			meas_stop <= state_reg == etc_pkg::st_meas && !abort_any &&
				stop_any;
			meas_abort <= state_reg == etc_pkg::st_meas && abort_any;
			// storage runs with its preset conditions, prompt never asked
			save_req <= !ui_inhibit && |req_save;
			event_mark <= !ui_inhibit && |req_mark &&
				state_reg == etc_pkg::st_meas;
			meas_active <= state_reg == etc_pkg::st_meas;
			post_active <= state_reg == etc_pkg::st_post;
		end
	end

	// external clock is gated off entirely under real-time saving
	assign ext_active = ext_reg && !rts_reg;
	assign smpl_edge = slope_reg ? rise[N_IN] : fall[N_IN];

	// first edge only opens the interval, so N points need N+1 pulses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_seen_reg <= 1'b0;
		end else if (state_reg != etc_pkg::st_meas) begin
			first_seen_reg <= 1'b0;
		end else if (ext_active && smpl_edge) begin
			first_seen_reg <= 1'b1;
		end
	end

	// sample strobe; an abort in the same cycle loses that point
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= state_reg == etc_pkg::st_meas && !abort_any &&
				ext_active && smpl_edge && first_seen_reg;
		end
	end

	// sample counter and division tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smpl_cnt_reg <= '0;
			div_cnt_reg <= '0;
			div_tick <= 1'b0;
		end else begin
			div_tick <= 1'b0;
			if (meas_start) begin
				smpl_cnt_reg <= '0;
				div_cnt_reg <= '0;
			end else if (sample_strobe) begin
				smpl_cnt_reg <= smpl_cnt_reg + 1'b1;
				if (div_cnt_reg >= div_reg - 1'b1) begin
					div_cnt_reg <= '0;
					div_tick <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg + 1'b1;
				end
			end
		end
	end

	// monitor is off as long as external sampling is active, so it stays on under real-time saving
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			calc_monitor_en <= 1'b1;
		end else begin
			calc_monitor_en <= !ext_active;
		end
	end

	// status condition selection
	always_comb begin
		case (sel1_reg)
			`ETC_SEL_JUDGE: cond1 = judge_pass;
			`ETC_SEL_ERROR: cond1 = dev_error;
			`ETC_SEL_BUSY: cond1 = busy_now;
			`ETC_SEL_WAIT: cond1 = wait_trig;
			default: cond1 = 1'b0;
		endcase
		case (sel2_reg)
			`ETC_SEL_JUDGE: cond2 = judge_fail;
			`ETC_SEL_ERROR: cond2 = dev_error;
			`ETC_SEL_BUSY: cond2 = busy_now;
			`ETC_SEL_WAIT: cond2 = wait_trig;
			default: cond2 = 1'b0;
		endcase
	end

	// open drain pins: enable only while pulling low, else released high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pass_status_out <= 1'b1;
			pass_status_oe <= 1'b0;
			fail_status_out <= 1'b1;
			fail_status_oe <= 1'b0;
		end else begin
			pass_status_out <= !cond1;
			pass_status_oe <= cond1;
			fail_status_out <= !cond2;
			fail_status_oe <= cond2;
		end
	end

	// bus address phase; zero wait states, always OKAY
	assign ap_take = hsel && htrans[1] && hready;

	// out of range division values clamp rather than fault the bus
	always_comb begin
		div_wr = hwdata[9:0];
		if (hwdata[31:10] != '0 || hwdata[9:0] > `ETC_DIV_MAX) begin
			div_wr = `ETC_DIV_MAX;
		end else if (hwdata[9:0] < `ETC_DIV_MIN) begin
			div_wr = `ETC_DIV_MIN;
		end
	end

	// write pending from address phase to data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ap_take && hwrite;
			if (ap_take) begin
				wr_addr_reg <= haddr[7:0];
			end
		end
	end

	// configuration registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_reg[0] <= `ETC_ACT_START;
			act_reg[1] <= `ETC_ACT_STOP;
			act_reg[2] <= `ETC_ACT_LEVEL;
			sel1_reg <= `ETC_SEL_JUDGE;
			sel2_reg <= `ETC_SEL_JUDGE;
			ext_reg <= 1'b0;
			slope_reg <= 1'b0;
			rts_reg <= 1'b0;
			div_reg <= `ETC_DIV_RST;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == `ETC_OFS_CFG) begin
				act_reg[0] <= hwdata[`ETC_CFG_ACT_A +: 3];
				act_reg[1] <= hwdata[`ETC_CFG_ACT_B +: 3];
				act_reg[2] <= hwdata[`ETC_CFG_ACT_C +: 3];
				sel1_reg <= hwdata[`ETC_CFG_SEL1 +: 2];
				sel2_reg <= hwdata[`ETC_CFG_SEL2 +: 2];
				ext_reg <= hwdata[`ETC_CFG_EXT];
				slope_reg <= hwdata[`ETC_CFG_SLOPE];
				rts_reg <= hwdata[`ETC_CFG_RTS];
			end else if (wr_addr_reg == `ETC_OFS_DIV) begin
				div_reg <= div_wr;
			end
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			`ETC_OFS_CFG: begin
				rd_mux[`ETC_CFG_ACT_A +: 3] = act_reg[0];
				rd_mux[`ETC_CFG_ACT_B +: 3] = act_reg[1];
				rd_mux[`ETC_CFG_ACT_C +: 3] = act_reg[2];
				rd_mux[`ETC_CFG_SEL1 +: 2] = sel1_reg;
				rd_mux[`ETC_CFG_SEL2 +: 2] = sel2_reg;
				rd_mux[`ETC_CFG_EXT] = ext_reg;
				rd_mux[`ETC_CFG_SLOPE] = slope_reg;
				rd_mux[`ETC_CFG_RTS] = rts_reg;
			end
			`ETC_OFS_DIV: rd_mux[9:0] = div_reg;
			`ETC_OFS_STAT: begin
				rd_mux[N_IN:0] = pin_s;
				rd_mux[`ETC_STAT_MEAS] = state_reg == etc_pkg::st_meas;
				rd_mux[`ETC_STAT_POST] = state_reg == etc_pkg::st_post;
				rd_mux[`ETC_STAT_EXT] = ext_active;
				rd_mux[`ETC_STAT_FIRST] = first_seen_reg;
				rd_mux[`ETC_STAT_BUSY] = busy_now;
			end
			`ETC_OFS_CNT: rd_mux[CNT_W-1:0] = smpl_cnt_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data registered at the address phase, stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ap_take && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end
endmodule

//--- sim/etc_top_monitor.sv
module etc_top_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic pass_status_out,
	input wire logic pass_status_oe,
	input wire logic fail_status_out,
	input wire logic fail_status_oe,
	input wire logic judge_pass,
	input wire logic judge_fail,
	input wire logic dev_error,
	input wire logic dev_busy,
	input wire logic wait_trig,
	input wire logic ui_inhibit,
	input wire logic meas_start,
	input wire logic meas_stop,
	input wire logic meas_abort,
	input wire logic save_req,
	input wire logic event_mark,
	input wire logic sample_strobe,
	input wire logic post_active,
	input wire logic calc_monitor_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] cfg;
	logic wr_ph;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// shadow of the config word, landing at the end of the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'h0;
			cfg <= 32'h00000210;
		end else begin
			wr_ph <= hsel && htrans[1] && hready && hwrite &&
				haddr[7:0] == 8'h00;
			if (wr_ph)
				cfg <= hwdata;
		end
	end
	// busy also covers post state, so it is judged on its own below
	function automatic logic cond(input logic [1:0] s, input logic j);
		case (s)
			2'h0: return j;
			2'h1: return dev_error;
			2'h2: return dev_busy;
			default: return wait_trig;
		endcase
	endfunction
	chk_pins_rest: assert property (
		pass_status_out == !pass_status_oe && fail_status_out == !fail_status_oe)
		else $error("status pin level and enable disagree");
	chk_out1_follow: assert property ($past(cfg[13:12]) != 2'h2 |->
		pass_status_oe == $past(cond(cfg[13:12], judge_pass)))
		else $error("first status output wrong");
	chk_out2_follow: assert property ($past(cfg[15:14]) != 2'h2 |->
		fail_status_oe == $past(cond(cfg[15:14], judge_fail)))
		else $error("second status output wrong");
	chk_busy_low: assert property (
		$past(cfg[13:12]) == 2'h2 && $past(dev_busy) |-> pass_status_oe)
		else $error("busy not shown");
	chk_stop_post: assert property (meas_stop |-> ##[0:2] post_active)
		else $error("stop without post processing");
	chk_abort_skip: assert property (meas_abort |-> !post_active [*3])
		else $error("abort entered post processing");
	chk_inhibit_quiet: assert property (
		ui_inhibit && $past(ui_inhibit) && $past(ui_inhibit, 2) |->
		!(meas_start || meas_stop || meas_abort || save_req || event_mark))
		else $error("action while inhibited");
	chk_calc_off: assert property (
		calc_monitor_en == !($past(cfg[16]) && !$past(cfg[18])))
		else $error("calc monitor enable wrong");
	chk_rts_no_smp: assert property (
		$past(cfg[18]) && cfg[18] |-> !sample_strobe)
		else $error("sample with real-time save");
	chk_start_once: assert property (meas_start |=> !meas_start)
		else $error("start pulse too long");
	cov_start: cover property (meas_start);
	cov_abort: cover property (meas_abort);
	cov_sample: cover property (sample_strobe);
	cov_save: cover property (save_req);
endmodule

//--- sim/etc_equip.sv
// external control equipment driving the terminal pins
module etc_equip #(
	parameter int HOLD = 750000,
	parameter int PH = 63
) (
	input wire logic clk,
	output logic ctrl_input_a,
	output logic ctrl_input_b,
	output logic ctrl_input_c,
	output logic ext_sample_clock_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] pins = 3'h7;
	logic [2:0] pins_q = 3'h7;
	int held = 0;
	initial ext_sample_clock_in = 1'h1;
	assign {ctrl_input_c, ctrl_input_b, ctrl_input_a} = pins;
	// age of the present pin levels; a short HOLD keeps runs brief
	always @(posedge clk) begin
		held <= (pins != pins_q) ? 0 : held + 1;
		pins_q <= pins;
	end
	// two edges let the age counter see the last change first
	task automatic set_pin(input int k, input logic v);
		repeat (2) @(posedge clk);
		while (held < HOLD) @(posedge clk);
		pins[k] <= v;
	endtask
	// phases of 63 cycles: 2.52 us each, period under 200 kHz
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			ext_sample_clock_in <= 1'h0;
			repeat (PH) @(posedge clk);
			ext_sample_clock_in <= 1'h1;
			repeat (PH - 1) @(posedge clk);
		end
	endtask
endmodule

//--- sim/etc_top_tb_top.sv
module etc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, meas_active, post_active, calc_monitor_en;
	logic judge_pass = 1'h0, judge_fail = 1'h0, dev_error = 1'h0;
	logic dev_busy = 1'h0, wait_trig = 1'h0, ui_inhibit = 1'h0;
	logic post_done = 1'h0;
	logic pass_status_out, pass_status_oe, fail_status_out, fail_status_oe;
	logic [6:0] pulses;
	wire logic ctrl_input_a, ctrl_input_b, ctrl_input_c, ext_sample_clock_in;
	int failures = 0, check_count = 0, n_smp = 0, n_div = 0, cyc;
	etc_top dut (.*, .hready(hreadyout), .hsize(3'h2),
		.meas_start(pulses[0]), .meas_stop(pulses[1]),
		.meas_abort(pulses[2]), .save_req(pulses[3]),
		.event_mark(pulses[4]), .sample_strobe(pulses[5]),
		.div_tick(pulses[6]));
	etc_equip #(.HOLD(8)) equip (.clk(hclk), .*);
	always #20 hclk = ~hclk;
	// sample and division tick counts
	always @(posedge hclk) begin
		if (pulses[5] === 1'h1)
			n_smp++;
		if (pulses[6] === 1'h1)
			n_div++;
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single AHB transfer; waits on hready, no fixed latency
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic wait_bit(input int k, input string what);
		for (cyc = 0; cyc < 40 && pulses[k] !== 1'h1; cyc++)
			@(negedge hclk);
		check(what, {31'h0, pulses[k]}, 32'h1);
	endtask
	// post processing lasts until the engine reports it done
	task automatic finish_post();
		for (cyc = 0; cyc < 40 && post_active !== 1'h1; cyc++)
			@(negedge hclk);
		check("post", {31'h0, post_active}, 32'h1);
		@(posedge hclk);
		post_done <= 1'h1;
		@(posedge hclk);
		post_done <= 1'h0;
		repeat (2) @(negedge hclk);
		check("idle", {meas_active, post_active}, 32'h0);
	endtask
	task automatic end_meas();
		equip.set_pin(0, 1'h1);
		equip.set_pin(1, 1'h0);
		wait_bit(1, "stop");
		finish_post();
		equip.set_pin(1, 1'h1);
	endtask
	task automatic t_reset();
		bus(1'h0, 8'h00, 32'h0);
		check("cfg", rd, 32'h00000210);
		bus(1'h0, 8'h04, 32'h0);
		check("div", rd, 32'h00000064);
		bus(1'h0, 8'h10, 32'h0);
		check("unmapped", rd, 32'h0);
		check("pins idle", {pass_status_out, fail_status_out}, 32'h3);
	endtask
	task automatic t_start_stop();
		equip.set_pin(0, 1'h0);
		wait_bit(0, "start");
		check("sync lag", {31'h0, cyc >= 4}, 32'h1);
		// the level output trails the start pulse by one cycle
		@(negedge hclk);
		check("measuring", {31'h0, meas_active}, 32'h1);
		end_meas();
		equip.set_pin(2, 1'h0);
		wait_bit(0, "level start");
		equip.set_pin(2, 1'h1);
		wait_bit(1, "level stop");
		// the level input already stopped; only post processing remains
		finish_post();
	endtask
	// start on a, mark on c, abort on b, then save on a
	task automatic t_actions();
		bus(1'h1, 8'h00, 32'h00000530);
		equip.set_pin(0, 1'h0);
		wait_bit(0, "start");
		equip.set_pin(2, 1'h0);
		wait_bit(4, "mark");
		equip.set_pin(1, 1'h0);
		wait_bit(2, "abort");
		repeat (3) @(negedge hclk);
		check("no post", {meas_active, post_active}, 32'h0);
		equip.set_pin(0, 1'h1);
		equip.set_pin(1, 1'h1);
		equip.set_pin(2, 1'h1);
		bus(1'h1, 8'h00, 32'h00000004);
		equip.set_pin(0, 1'h0);
		wait_bit(3, "save");
		equip.set_pin(0, 1'h1);
		bus(1'h1, 8'h00, 32'h00000210);
	endtask
	task automatic t_inhibit();
		@(posedge hclk);
		ui_inhibit <= 1'h1;
		equip.set_pin(0, 1'h0);
		repeat (8) @(negedge hclk);
		check("inhibited", {31'h0, meas_active}, 32'h0);
		equip.set_pin(0, 1'h1);
		@(posedge hclk);
		ui_inhibit <= 1'h0;
	endtask
	// every condition on both outputs; each mode's cause is one-hot
	task automatic t_status();
		for (int s = 0; s < 4; s++) begin
			bus(1'h1, 8'h00, 32'h00000210 | (s << 12) | (s << 14));
			@(posedge hclk);
			{wait_trig, dev_busy, dev_error, judge_pass} <= 4'h1 << s;
			repeat (3) @(negedge hclk);
			check("out1", {pass_status_out, pass_status_oe}, 32'h1);
			check("out2", {31'h0, fail_status_out}, s == 0);
		end
		bus(1'h1, 8'h00, 32'h00000210);
		{wait_trig, dev_busy, dev_error, judge_pass} <= 4'h0;
		judge_fail <= 1'h1;
		repeat (3) @(negedge hclk);
		check("judge fail", {pass_status_out, fail_status_out}, 32'h2);
		@(posedge hclk);
		judge_fail <= 1'h0;
		repeat (3) @(negedge hclk);
		check("rest", {pass_status_out, fail_status_out}, 32'h3);
	endtask
	task automatic t_ext();
		bus(1'h1, 8'h04, 32'h00000005);
		bus(1'h0, 8'h04, 32'h0);
		check("div low", rd, 32'h0000000a);
		bus(1'h1, 8'h04, 32'h000007d0);
		bus(1'h0, 8'h04, 32'h0);
		check("div high", rd, 32'h000003e8);
		bus(1'h1, 8'h04, 32'h0000000a);
		bus(1'h1, 8'h00, 32'h00010210);
		repeat (2) @(negedge hclk);
		check("calc off", {31'h0, calc_monitor_en}, 32'h0);
		// falling slope, then rising slope, then real-time save blocking
		for (int r = 0; r < 3; r++) begin
			equip.set_pin(0, 1'h0);
			wait_bit(0, "start");
			n_smp = 0;
			n_div = 0;
			equip.pulses(11);
			repeat (8) @(negedge hclk);
			check("samples", n_smp, r == 2 ? 0 : 10);
			check("ticks", n_div, r == 2 ? 0 : 1);
			if (r < 2) begin
				bus(1'h0, 8'h0c, 32'h0);
				check("count", {16'h0, rd[15:0]}, 32'h0000000a);
			end
			end_meas();
			bus(1'h1, 8'h00, r ? 32'h00070210 : 32'h00030210);
			repeat (2) @(negedge hclk);
			check("calc", {31'h0, calc_monitor_en}, r != 0);
		end
		bus(1'h1, 8'h00, 32'h00000210);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset();
		t_start_stop();
		t_actions();
		t_inhibit();
		t_status();
		t_ext();
		wrap_up();
	end
	// the full run needs about 5000 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		wrap_up();
	end
endmodule
bind etc_top etc_top_monitor mon (.*);
